// [inc/cir_defs.svh]
/*
  constants of the accessory id interrupt block: addresses, field positions,
  masks and timing. assumes inclusion by bare name from the design files.
*/
`ifndef CIR_DEFS_SVH
`define CIR_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register addresses
`define CIR_A_EN        8'h1d
`define CIR_A_STATE     8'h20
`define CIR_A_LATCH     8'h21
`define CIR_A_VEN       8'h36
`define CIR_TRIO_SPAN   8'h02
`define CIR_EXT_CODE    6'h2f

////////////////////////////////////////////////////////////////////////////////
// register operations, by offset from the trio base
`define CIR_OP_WR       2'h0
`define CIR_OP_SET      2'h1
`define CIR_OP_CLR      2'h2

////////////////////////////////////////////////////////////////////////////////
// fields
`define CIR_EN_RISE     0
`define CIR_EN_FALL     1
`define CIR_EN_DONE     5
`define CIR_EN_MASK     8'h23
`define CIR_ST_OPEN     0
`define CIR_ST_CODE     3
`define CIR_ST_DONE     6
`define CIR_LT_OPEN     0
`define CIR_LT_DONE     3
`define CIR_LT_MASK     8'h09
`define CIR_VEN_CODE    0
`define CIR_VEN_DONE    3
`define CIR_VEN_GO      4
`define CIR_VEN_IRQ     6
`define CIR_CODE_W      3
`define CIR_RX_ALT      7

////////////////////////////////////////////////////////////////////////////////
// link commands and timing
`define CIR_CMD_WRITE   2'h2
`define CIR_CMD_READ    2'h3
`define CIR_CONV_TIME_US 282
`define CIR_CLK_MHZ     20

`endif

// [inc/cir_pkg.sv]
/*
  types shared by the accessory id interrupt block.
  assumes nothing beyond a systemverilog compiler.
*/
package cir_pkg;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } cir_req_t;

  typedef enum logic [3:0] {
    L_IDLE, L_ACK, L_EADDR, L_WDATA, L_WBUSY, L_WSTP, L_RBUSY,
    L_RTURN, L_RDATA, L_RBACK, L_XTURN, L_XCMD, L_XBACK
  } cir_lstate_t;

endpackage : cir_pkg

// [rtl/cir_bit_sync.sv]
/*
  two flop synchroniser for levels and toggles.
  assumes each bit is independent or held stable while it crosses.
*/
`timescale 1ns/10ps
module cir_bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // no reset: the synchroniser also carries the reset itself
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out  <= meta_q;
  end

endmodule : cir_bit_sync

// [rtl/cir_conv_timer.sv]
/*
  id resistance conversion timer: one done strobe a fixed count after start.
  assumes run_in stays high until the done strobe has been seen.
*/
`timescale 1ns/10ps
`include "cir_defs.svh"
module cir_conv_timer #(
  parameter int unsigned CYCLES = `CIR_CONV_TIME_US * `CIR_CLK_MHZ
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      done_out
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // [RL7] conversion length count
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in || done_out) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= run_in && (cnt_q == LAST) && !done_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $rose(run_in);
  endsequence

  property p_conv_early;
    @(posedge clk_in) disable iff (rst_in) s_start |-> !done_out [*8];
  endproperty
  a_conv_early: assert property (p_conv_early) else $error("conversion ended early"); // [RL7]

  property p_conv_count;
    @(posedge clk_in) disable iff (rst_in) done_out |-> $past(cnt_q) == LAST;
  endproperty
  a_conv_count: assert property (p_conv_count) else $error("conversion length wrong"); // [RL7]

endmodule : cir_conv_timer

// [rtl/cir_top.sv]
/*
  accessory id interrupt registers of a ulpi transceiver: enable, live
  status, clear on read latch, vendor conversion control, and the ulpi
  register front end on the link clock with alt_int reporting in rxcmd.
  assumes a free running ulpi clock and a link that follows ulpi framing.
*/
// Function
// [RL1] id pin going floating with rising enable raises alt_int
// [RL2] id pin leaving floating with falling enable raises alt_int
// [RL3] unimplemented and reserved bits always read zero
// [RL4] conversion done enable is ored with the vendor enable
// [RL5] link should enable the id pull-up before trusting float events
// [RL6] status bits 5:3 report the measured id resistance code
// [RL7] conversion done flag sets after a 282 us conversion
// [RL8] done flag clears only on a vendor conversion register read
// [RL9] latch bit 0 sets on an enabled id float edge
// [RL10] latch bit 3 sets on an enabled done flag rise
// [RL11] latch register at 21h is read only and clears on read
// [RL12] enable register reads at 1dh-1fh, writes load, set or clear
// [RL13] status register at 20h is read only with no side effect
// [RL14] registers 00h-3fh reachable by immediate and extended commands
// [RL15] vendor range 30h-3fh reachable by immediate commands
// [RL16] conversion start bit launches a measurement and self clears
// [RL17] set address ors ones in, clear address zeroes written ones
// [RL18] any latched event shows as alt_int in the next rxcmd
`timescale 1ns/10ps
`include "cir_defs.svh"
module cir_top #(
  parameter int unsigned CONV_CYCLES = `CIR_CONV_TIME_US * `CIR_CLK_MHZ
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ulpi_clk_in,
  input  wire logic [7:0] ulpi_data_in,
  output logic      [7:0] ulpi_data_out,
  output logic            ulpi_data_oe_out,
  output logic            ulpi_dir_out,
  output logic            ulpi_nxt_out,
  input  wire logic       ulpi_stp_in,
  input  wire logic       ident_open_in,
  input  wire logic [2:0] ident_resistance_code_in,
  output logic            resistance_measure_go_out
);

  ////////////////////////////////////////////////////////////////////////////
  // shared declarations
  cir_pkg::cir_req_t    req_q;
  cir_pkg::cir_lstate_t st_q;
  cir_pkg::cir_lstate_t ret_q;
  logic       req_tgl_q;
  logic       ack_tgl_q;
  logic [7:0] rdata_q;
  logic [7:0] latch_q;

  function automatic logic in_trio(input logic [7:0] a, input logic [7:0] base);
    in_trio = (a >= base) && (a <= base + `CIR_TRIO_SPAN);
  endfunction : in_trio

  function automatic logic [7:0] reg_op(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic [7:0] a,
                                        input logic [7:0] base);
    logic [7:0] k;
    k = a - base;
    case (k[1:0])
      `CIR_OP_WR:  reg_op = wd;
      `CIR_OP_SET: reg_op = old | wd;
      `CIR_OP_CLR: reg_op = old & ~wd;
      default:     reg_op = old;
    endcase
  endfunction : reg_op

  ////////////////////////////////////////////////////////////////////////////
  // core domain: synchronisers
  logic [3:0] pin_sync;
  logic       req_sync;
  logic       open_now;
  logic [2:0] code_now;

  // code bits are only sampled at conversion end, when the converter is settled
  cir_bit_sync #(.WIDTH(4)) u_pin_sync (
    .clk_in (clk_in),
    .d_in   ({ident_open_in, ident_resistance_code_in}),
    .q_out  (pin_sync)
  );

  cir_bit_sync #(.WIDTH(1)) u_req_sync (
    .clk_in (clk_in),
    .d_in   (req_tgl_q),
    .q_out  (req_sync)
  );

  assign open_now = pin_sync[3];
  assign code_now = pin_sync[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // core domain: register access
  logic       req_seen_q;
  logic       fire;
  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] enable_q;
  logic       go_q;
  logic       ven_irq_q;
  logic       done_q;
  logic       done_pulse;
  logic [2:0] code_q;
  logic       open_prev_q;
  logic       irq_en_any;
  logic [7:0] latch_set;
  logic [7:0] state_view;
  logic [7:0] ven_view;
  logic [7:0] ven_new;
  logic [7:0] rd_value;

  // request words are stable in the link domain while the toggle is unanswered
  assign fire    = req_sync ^ req_seen_q;
  assign wr_fire = fire & req_q.write;
  assign rd_fire = fire & ~req_q.write;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
    end else begin
      req_seen_q <= req_sync;
      // tracking the synced toggle heals an unknown start after reset skew
      ack_tgl_q  <= req_sync;
    end
  end

  // [RL12] enable load, set, clear
  // [RL17] set ors, clear zeroes ones
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enable_q <= 8'h00;
    end else if (wr_fire && in_trio(req_q.addr, `CIR_A_EN)) begin
      enable_q <= reg_op(enable_q, req_q.data, req_q.addr, `CIR_A_EN) & `CIR_EN_MASK;
    end
  end

  assign ven_new = reg_op(ven_view, req_q.data, req_q.addr, `CIR_A_VEN);

  // [RL16] start bit self clears on done
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      go_q      <= 1'b0;
      ven_irq_q <= 1'b0;
    end else begin
      if (done_pulse) begin
        go_q <= 1'b0;
      end else if (wr_fire && in_trio(req_q.addr, `CIR_A_VEN)) begin
        go_q <= ven_new[`CIR_VEN_GO];
      end
      if (wr_fire && in_trio(req_q.addr, `CIR_A_VEN)) begin
        ven_irq_q <= ven_new[`CIR_VEN_IRQ];
      end
    end
  end

  assign resistance_measure_go_out = go_q;

  cir_conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (go_q),
    .done_out (done_pulse)
  );

  // [RL7] done sets at conversion end
  // [RL8] only a vendor read clears; set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      code_q <= '0;
    end else begin
      if (done_pulse) begin
        done_q <= 1'b1;
        code_q <= code_now;
      end else if (rd_fire && in_trio(req_q.addr, `CIR_A_VEN)) begin
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    open_prev_q <= open_now;
  end

  // [RL4] either enable arms the done event
  assign irq_en_any = enable_q[`CIR_EN_DONE] | ven_irq_q;

  // [RL1] [RL2] [RL9] [RL10] event detection
  always_comb begin
    latch_set = 8'h00;
    latch_set[`CIR_LT_OPEN] = (open_now & ~open_prev_q & enable_q[`CIR_EN_RISE]) |
                              (~open_now & open_prev_q & enable_q[`CIR_EN_FALL]);
    latch_set[`CIR_LT_DONE] = done_pulse & ~done_q & irq_en_any;
  end

  // [RL11] clear on read, set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      latch_q <= 8'h00;
    end else if (rd_fire && (req_q.addr == `CIR_A_LATCH)) begin
      latch_q <= latch_set;
    end else begin
      latch_q <= latch_q | latch_set;
    end
  end

  // [RL3] unused bits left zero
  // [RL6] [RL13] live status view
  always_comb begin
    state_view = 8'h00;
    state_view[`CIR_ST_OPEN] = open_now;
    state_view[`CIR_ST_CODE +: `CIR_CODE_W] = code_q;
    state_view[`CIR_ST_DONE] = done_q;
    ven_view = 8'h00;
    ven_view[`CIR_VEN_CODE +: `CIR_CODE_W] = code_q;
    ven_view[`CIR_VEN_DONE] = done_q;
    ven_view[`CIR_VEN_GO] = go_q;
    ven_view[`CIR_VEN_IRQ] = ven_irq_q;
  end

  // [RL14] [RL15] one map for both command forms
  always_comb begin
    rd_value = 8'h00;
    if (in_trio(req_q.addr, `CIR_A_EN)) begin
      rd_value = enable_q;
    end else if (req_q.addr == `CIR_A_STATE) begin
      rd_value = state_view;
    end else if (req_q.addr == `CIR_A_LATCH) begin
      rd_value = latch_q;
    end else if (in_trio(req_q.addr, `CIR_A_VEN)) begin
      rd_value = ven_view;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (rd_fire) begin
      rdata_q <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain checks
  property p_rise_latch;
    @(posedge clk_in) disable iff (rst_in)
      (open_now && !open_prev_q && enable_q[`CIR_EN_RISE]) |=> latch_q[`CIR_LT_OPEN];
  endproperty
  a_rise_latch: assert property (p_rise_latch) else $error("float rise not latched"); // [RL1]

  property p_fall_latch;
    @(posedge clk_in) disable iff (rst_in)
      (!open_now && open_prev_q && enable_q[`CIR_EN_FALL]) |=> latch_q[`CIR_LT_OPEN];
  endproperty
  a_fall_latch: assert property (p_fall_latch) else $error("float fall not latched"); // [RL2]

  property p_no_enable_no_latch;
    @(posedge clk_in) disable iff (rst_in)
      (!latch_q[`CIR_LT_OPEN] && enable_q[`CIR_EN_RISE +: 2] == 2'h0) |=> !latch_q[`CIR_LT_OPEN];
  endproperty
  a_no_enable_no_latch: assert property (p_no_enable_no_latch) else $error("latch set unarmed"); // [RL9]

  property p_zero_bits;
    @(posedge clk_in) disable iff (rst_in)
      ((enable_q & ~`CIR_EN_MASK) == 8'h00) && ((latch_q & ~`CIR_LT_MASK) == 8'h00);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit set"); // [RL3]

  property p_done_latch;
    @(posedge clk_in) disable iff (rst_in)
      (done_pulse && !done_q && irq_en_any) |=> latch_q[`CIR_LT_DONE] && done_q;
  endproperty
  a_done_latch: assert property (p_done_latch) else $error("done event not latched"); // [RL10]

  property p_done_hold;
    @(posedge clk_in) disable iff (rst_in)
      (done_q && !(rd_fire && in_trio(req_q.addr, `CIR_A_VEN))) |=> done_q;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost"); // [RL8]

  property p_latch_clear;
    @(posedge clk_in) disable iff (rst_in)
      (rd_fire && req_q.addr == `CIR_A_LATCH && latch_set == 8'h00) |=> latch_q == 8'h00;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // [RL11]

  property p_en_set;
    @(posedge clk_in) disable iff (rst_in)
      (wr_fire && req_q.addr == `CIR_A_EN + 8'h01) |=>
        enable_q == (($past(enable_q) | $past(req_q.data)) & `CIR_EN_MASK);
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set wrong"); // [RL17]

  property p_go_clear;
    @(posedge clk_in) disable iff (rst_in) done_pulse |=> !go_q ##1 !done_pulse;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("start bit not cleared"); // [RL16]

  ////////////////////////////////////////////////////////////////////////////
  // link domain
  logic [1:0] link_sync;
  logic       link_rst;
  logic       ack_sync;
  logic       alt_sync;
  logic       alt_sent_q;
  logic [1:0] cmd;
  logic       is_reg;
  logic       is_ext;
  logic       link_done;
  logic       rx_go;

  cir_bit_sync #(.WIDTH(1)) u_rst_sync (
    .clk_in (ulpi_clk_in),
    .d_in   (rst_in),
    .q_out  (link_rst)
  );

  cir_bit_sync #(.WIDTH(2)) u_link_sync (
    .clk_in (ulpi_clk_in),
    .d_in   ({|latch_q, ack_tgl_q}),
    .q_out  (link_sync)
  );

  assign alt_sync  = link_sync[1];
  assign ack_sync  = link_sync[0];
  assign cmd       = ulpi_data_in[7:6];
  assign is_reg    = (cmd == `CIR_CMD_WRITE) || (cmd == `CIR_CMD_READ);
  assign is_ext    = (ulpi_data_in[5:0] == `CIR_EXT_CODE);
  assign link_done = (req_tgl_q == ack_sync);
  // bus turned over only while the link idles, so no command is cut short
  assign rx_go     = !is_reg && (alt_sync != alt_sent_q) &&
                     (ulpi_data_in == 8'h00) && !ulpi_stp_in;

  // [RL14] immediate and extended framing
  always_ff @(posedge ulpi_clk_in) begin
    if (link_rst) begin
      st_q  <= cir_pkg::L_IDLE;
      ret_q <= cir_pkg::L_IDLE;
    end else begin
      case (st_q)
        cir_pkg::L_IDLE: begin
          if (is_reg && is_ext) begin
            st_q  <= cir_pkg::L_ACK;
            ret_q <= cir_pkg::L_EADDR;
          end else if (is_reg && cmd == `CIR_CMD_WRITE) begin
            st_q  <= cir_pkg::L_ACK;
            ret_q <= cir_pkg::L_WDATA;
          end else if (is_reg) begin
            st_q <= cir_pkg::L_RBUSY;
          end else if (rx_go) begin
            st_q <= cir_pkg::L_XTURN;
          end
        end
        cir_pkg::L_ACK:   st_q <= ret_q;
        cir_pkg::L_EADDR: begin
          if (req_q.write) begin
            st_q  <= cir_pkg::L_ACK;
            ret_q <= cir_pkg::L_WDATA;
          end else begin
            st_q <= cir_pkg::L_RBUSY;
          end
        end
        cir_pkg::L_WDATA: st_q <= cir_pkg::L_WBUSY;
        cir_pkg::L_WBUSY: begin
          if (link_done) begin
            st_q  <= cir_pkg::L_ACK;
            ret_q <= cir_pkg::L_WSTP;
          end
        end
        cir_pkg::L_WSTP: begin
          if (ulpi_stp_in) begin
            st_q <= cir_pkg::L_IDLE;
          end
        end
        cir_pkg::L_RBUSY: begin
          if (link_done) begin
            st_q  <= cir_pkg::L_ACK;
            ret_q <= cir_pkg::L_RTURN;
          end
        end
        cir_pkg::L_RTURN: st_q <= cir_pkg::L_RDATA;
        cir_pkg::L_RDATA: st_q <= cir_pkg::L_RBACK;
        cir_pkg::L_XTURN: st_q <= cir_pkg::L_XCMD;
        cir_pkg::L_XCMD:  st_q <= cir_pkg::L_XBACK;
        default:          st_q <= cir_pkg::L_IDLE;
      endcase
    end
  end

  // request capture; the toggle marks a complete word
  always_ff @(posedge ulpi_clk_in) begin
    if (link_rst) begin
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end else if (st_q == cir_pkg::L_IDLE && is_reg) begin
      req_q.write <= (cmd == `CIR_CMD_WRITE);
      req_q.addr  <= {2'h0, ulpi_data_in[5:0]};
      req_tgl_q   <= req_tgl_q ^ (!is_ext && cmd == `CIR_CMD_READ);
    end else if (st_q == cir_pkg::L_EADDR) begin
      req_q.addr <= ulpi_data_in;
      req_tgl_q  <= req_tgl_q ^ !req_q.write;
    end else if (st_q == cir_pkg::L_WDATA) begin
      req_q.data <= ulpi_data_in;
      req_tgl_q  <= ~req_tgl_q;
    end
  end

  // [RL18] alt_int carried in the rxcmd
  always_ff @(posedge ulpi_clk_in) begin
    if (link_rst) begin
      ulpi_data_out <= 8'h00;
      alt_sent_q    <= 1'b0;
    end else if (st_q == cir_pkg::L_RBUSY && link_done) begin
      ulpi_data_out <= rdata_q;
    end else if (st_q == cir_pkg::L_IDLE && rx_go) begin
      ulpi_data_out <= 8'h00;
      ulpi_data_out[`CIR_RX_ALT] <= alt_sync;
      alt_sent_q <= alt_sync;
    end
  end

  assign ulpi_nxt_out     = (st_q == cir_pkg::L_ACK);
  assign ulpi_dir_out     = (st_q == cir_pkg::L_RTURN) || (st_q == cir_pkg::L_RDATA) ||
                            (st_q == cir_pkg::L_XTURN) || (st_q == cir_pkg::L_XCMD);
  assign ulpi_data_oe_out = (st_q == cir_pkg::L_RDATA) || (st_q == cir_pkg::L_XCMD);

  ////////////////////////////////////////////////////////////////////////////
  // link domain checks
  sequence s_read_tail;
    ulpi_dir_out && !ulpi_data_oe_out ##1 ulpi_data_oe_out ##1 !ulpi_dir_out;
  endsequence

  property p_read_frame;
    @(posedge ulpi_clk_in) disable iff (link_rst)
      (ulpi_nxt_out && ret_q == cir_pkg::L_RTURN) |=> s_read_tail;
  endproperty
  a_read_frame: assert property (p_read_frame) else $error("read turnaround wrong"); // [RL14]

  property p_rx_alt;
    @(posedge ulpi_clk_in) disable iff (link_rst)
      (st_q == cir_pkg::L_IDLE && rx_go) |-> ##2
        (ulpi_data_oe_out && ulpi_data_out[`CIR_RX_ALT] == $past(alt_sync, 2));
  endproperty
  a_rx_alt: assert property (p_rx_alt) else $error("rxcmd alt_int wrong"); // [RL18]

endmodule : cir_top

// [dv/cir_link_model.sv]
/*
  ulpi link model: register writes and reads, immediate or extended, and
  alt_int tracking from rxcmd bytes. assumes the phy answers per ulpi.
*/
`timescale 1ns/10ps
`include "cir_defs.svh"
module cir_link_model (
  input  wire logic       clk_in,
  input  wire logic       dir_in,
  input  wire logic       nxt_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out,
  output logic            stp_out,
  output logic            alt_out,
  output logic            tmo_out
);
  logic busy;
  initial begin
    d_out = 8'h00;
    stp_out = 1'b0;
    alt_out = 1'b0;
    tmo_out = 1'b0;
    busy = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // only bytes outside own reads are rxcmds
  always @(posedge clk_in)
    if (dir_in && oe_in && !busy) alt_out <= d_in[`CIR_RX_ALT];
  // hold the byte until nxt is sampled high
  task automatic send(input logic [7:0] b);
    int n;
    while (dir_in) @(negedge clk_in);
    d_out = b;
    n = 0;
    @(posedge clk_in);
    while (nxt_in !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_in);
    end
    if (n >= 300) tmo_out = 1'b1;
    @(negedge clk_in);
  endtask : send
  task automatic head(input logic [1:0] c, input logic [7:0] a, input bit ext);
    if (ext) begin
      send({c, `CIR_EXT_CODE});
      send(a);
    end else send({c, a[5:0]});
  endtask : head
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input bit ext);
    @(negedge clk_in);
    head(`CIR_CMD_WRITE, a, ext);
    send(v);
    stp_out = 1'b1;
    d_out = 8'h00;
    @(negedge clk_in);
    stp_out = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input bit ext, output logic [7:0] v);
    int n;
    @(negedge clk_in);
    head(`CIR_CMD_READ, a, ext);
    // an rxcmd may still run before the command is taken
    busy = 1'b1;
    d_out = 8'h00;
    n = 0;
    @(posedge clk_in);
    while (!(dir_in && oe_in) && n < 20) begin
      n++;
      @(posedge clk_in);
    end
    if (n >= 20) tmo_out = 1'b1;
    v = d_in;
    @(negedge clk_in);
    busy = 1'b0;
  endtask : rd
endmodule : cir_link_model

// [dv/testbench.sv]
/*
  bench: link model, register model, id pin and code stimulus.
  assumes the cir_top map and a shortened conversion count.
*/
`timescale 1ns/10ps
`include "cir_defs.svh"
module testbench;
  localparam int unsigned CONV = 20;
  logic       clk_in = 1'b0;
  logic       u_clk = 1'b0;
  logic       rst_in = 1'b1;
  logic [7:0] di, dq, en;
  logic       oe, dir, nxt, stp, opn, go, alt, tmo;
  logic [2:0] code;
  int         n_mismatch = 0;
  int         tests_run = 0;
  always #25 clk_in = ~clk_in;
  always #32 u_clk = ~u_clk;
  cir_top #(.CONV_CYCLES(CONV)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .ulpi_clk_in(u_clk), .ulpi_data_in(di), .ulpi_data_out(dq),
    .ulpi_data_oe_out(oe), .ulpi_dir_out(dir), .ulpi_nxt_out(nxt),
    .ulpi_stp_in(stp), .ident_open_in(opn), .ident_resistance_code_in(code),
    .resistance_measure_go_out(go));
  cir_link_model lnk (.clk_in(u_clk), .dir_in(dir), .nxt_in(nxt), .oe_in(oe),
    .d_in(dq), .d_out(di), .stp_out(stp), .alt_out(alt), .tmo_out(tmo));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input bit ext, input logic [7:0] exp);
    logic [7:0] v;
    lnk.rd(a, ext, v);
    chk(v, exp);
  endtask : rchk
  task automatic wait_alt(input logic v);
    int n;
    n = 0;
    while (alt !== v && n < 100) begin
      n++;
      @(posedge u_clk);
    end
    chk({7'h00, alt}, {7'h00, v});
  endtask : wait_alt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // a run needs well under 200 us
  initial begin
    #400us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    logic [7:0] d;
    int k;
    int n;
    opn = 1'b0;
    code = 3'h0;
    en = 8'h00;
    void'($urandom(32'h314e));
    // sync reset also crosses into the link domain
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge u_clk);
    lnk.wr(`CIR_A_LATCH, 8'hff, 1'b0);
    lnk.wr(`CIR_A_STATE, 8'hff, 1'b1);
    rchk(`CIR_A_EN, 1'b0, 8'h00);
    rchk(`CIR_A_STATE, 1'b0, 8'h00);
    rchk(`CIR_A_LATCH, 1'b1, 8'h00);
    rchk(8'h05, 1'b0, 8'h00);
    rchk(8'h45, 1'b1, 8'h00);
    for (k = 0; k < 9; k++) begin
      d = 8'($urandom);
      lnk.wr(`CIR_A_EN + 8'(k % 3), d, k[1]);
      en = (k % 3 == 0) ? d : (k % 3 == 1) ? (en | d) : (en & ~d);
      en = en & `CIR_EN_MASK;
      rchk(`CIR_A_EN + 8'((k + 1) % 3), k[0], en);
    end
    // pull-up taken as on: the pin model gives clean float levels
    // pin toggles 0-1-0-1-0, enables picked so only the first two fire
    for (k = 0; k < 4; k++) begin
      en = (k == 0 || k == 3) ? 8'h01 : 8'h02;
      lnk.wr(`CIR_A_EN, en, 1'b0);
      @(negedge clk_in);
      opn = ~opn;
      wait_alt(k < 2);
      rchk(`CIR_A_STATE, 1'b0, {7'h00, opn});
      rchk(`CIR_A_LATCH, 1'b0, {7'h00, k < 2});
      rchk(`CIR_A_LATCH, 1'b1, 8'h00);
      wait_alt(1'b0);
    end
    // conversion via own enable, then via vendor enable
    for (k = 0; k < 2; k++) begin
      @(negedge clk_in);
      code = 3'($urandom);
      lnk.wr(`CIR_A_EN, k ? 8'h00 : 8'h20, 1'b0);
      lnk.wr(`CIR_A_VEN, k ? 8'h50 : 8'h10, 1'b0);
      chk({7'h00, go}, 8'h01);
      n = 0;
      while (go !== 1'b0 && n < 200) begin
        n++;
        @(posedge clk_in);
      end
      chk({7'h00, go}, 8'h00);
      // go rose a few cycles before the write returned, falls one after done
      chk({7'h00, n > CONV / 2 && n <= CONV + 1}, 8'h01);
      wait_alt(1'b1);
      rchk(`CIR_A_STATE, 1'b0, {2'b01, code, 3'h0});
      rchk(`CIR_A_STATE, 1'b1, {2'b01, code, 3'h0});
      rchk(`CIR_A_LATCH, 1'b0, 8'h08);
      rchk(`CIR_A_VEN + 8'(k), 1'b0, {1'b0, k[0], 3'b001, code});
      rchk(`CIR_A_STATE, 1'b0, {2'b00, code, 3'h0});
      wait_alt(1'b0);
    end
    chk({7'h00, tmo}, 8'h00);
    print_verdict();
  end
endmodule : testbench
